// [design/hue_pkg.sv]
`default_nettype none
package hue_pkg;
    // register offsets (host address)
    localparam logic [2:0] OFS_DATA = 3'h0;  // receive_buffer / transmit_holding / divisor_low_byte
    localparam logic [2:0] OFS_IER  = 3'h1;  // interrupt_enable / divisor_high_byte
    localparam logic [2:0] OFS_IIR  = 3'h2;  // interrupt_identification / fifo_control
    localparam logic [2:0] OFS_LCR  = 3'h3;  // line_control
    localparam logic [2:0] OFS_MCR  = 3'h4;  // modem_control / extended_status_control
    localparam logic [2:0] OFS_LSR  = 3'h5;  // line_status
    localparam logic [2:0] OFS_MSR  = 3'h6;  // modem_status
    localparam logic [2:0] OFS_SCR  = 3'h7;  // scratch / extended_divisor
    // interrupt identification codes, bits 3:1
    localparam logic [2:0] ID_LINE  = 3'h3;
    localparam logic [2:0] ID_RXTRG = 3'h2;
    localparam logic [2:0] ID_RXTMO = 3'h6;
    localparam logic [2:0] ID_TRANSMIT_HOLDING_EMPTY_FLAG  = 3'h1;
    localparam logic [2:0] ID_MDM   = 3'h0;
    // field positions
    localparam int FCR_EN    = 0;
    localparam int FCR_RXRST = 1;
    localparam int FCR_TXRST = 2;
    localparam int FCR_MODE  = 3;
    localparam int LCR_DIVISOR_ACCESS_BIT  = 7;
    localparam int LCR_BRK   = 6;
    localparam int MCR_LOOP  = 4;
    localparam int MCR_INTEN = 3;
    localparam int MCX_TMREN = 0;
    localparam int MCX_RXSH  = 1;
    localparam int MCX_TXSH  = 2;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SCR  = 8'hFF;
    // receive timer interval, ns, and cycles at 25 MHz
    localparam int CLK_NS       = 40;
    localparam int RX_DELAY_NS  = 400;
    localparam int RX_DELAY_CYC = (RX_DELAY_NS + CLK_NS - 1) / CLK_NS;
endpackage : hue_pkg
`default_nettype wire

// [design/hue_top.sv]
// Our own choice: the plain strobed port.
`default_nettype none
module hue_top
    import hue_pkg::*;
#(
    parameter int DEPTH = 16,            // fifo depth
    parameter int AW    = 4              // fifo pointer width
) (
    input  wire  logic       clk,
    input  wire  logic       rst,
    // host register port
    input  wire  logic [2:0] host_addr,
    input  wire  logic [7:0] host_wdata,
    input  wire  logic       host_wr,
    input  wire  logic       host_rd,
    output logic       [7:0] host_rdata,
    output logic             host_irq,
    output logic             irq_tristate_n,
    // controller side
    input  wire  logic       ctl_rx_wr,
    input  wire  logic [7:0] ctl_rx_data,
    input  wire  logic       ctl_err_wr,
    input  wire  logic [2:0] ctl_err_bits,
    input  wire  logic       ctl_rx_timeout,
    input  wire  logic       ctl_tx_rd,
    output logic       [7:0] ctl_tx_data,
    output logic             ctl_tx_avail,
    output logic             ctl_data_ready,
    // modem status inputs and control outputs
    input  wire  logic       cts_in,
    input  wire  logic       dsr_in,
    input  wire  logic       ri_in,
    input  wire  logic       dcd_in,
    output logic       [3:0] modem_ctl_out,
    output logic             break_out,
    output logic       [2:0] parity_ctl
);
    // full depth needs the extra pointer bit; an AW-wide cast would wrap to zero
    localparam logic [AW:0] CAP_FULL = (AW+1)'(DEPTH);

    // trigger level decode, used for rx and tx
    function automatic logic [AW:0] trig_lvl(input logic [1:0] sel);
        unique case (sel)
            2'b00:   trig_lvl = (AW+1)'(1);
            2'b01:   trig_lvl = (AW+1)'(4);
            2'b10:   trig_lvl = (AW+1)'(8);
            default: trig_lvl = (AW+1)'(14);
        endcase
    endfunction : trig_lvl

    logic [7:0]    ier_reg, lcr_reg, mcr_reg, scr_reg;    // general set
    logic [7:0]    dll_reg, dlm_reg, dlx_reg, mcx_reg;    // special set
    logic          fen_reg, mode_reg;                    // fifo enable, multi-byte mode
    logic [1:0]    trg_reg;                              // trigger select
    logic [10:0]   rx_mem [DEPTH];                       // {err[2:0], data}
    logic [7:0]    tx_mem [DEPTH];
    logic [AW-1:0] rx_wp_reg, rx_rp_reg, tx_wp_reg, tx_rp_reg;
    logic [AW:0]   rx_cnt_reg, tx_cnt_reg, err_cnt_reg;
    logic [2:0]    shadow_err_reg;                       // errors for next byte
    logic [2:0]    lsr_err_reg;                          // lsr bits 4:2
    logic          head_seen_reg;                        // head byte flags already loaded
    logic          overrun_reg, transmit_holding_empty_flag_reg, transmit_holding_empty_flag_int_reg, tmo_reg, host_dr_reg;
    logic [$clog2(RX_DELAY_CYC+1)-1:0] dly_reg;          // receive timer
    logic [3:0]    msr_delta_reg, msr_prev_reg;

    // decode
    wire divisor_access_bit     = lcr_reg[LCR_DIVISOR_ACCESS_BIT];
    wire loop     = mcr_reg[MCR_LOOP];
    wire fmode    = fen_reg & mode_reg;
    wire rd_data  = host_rd & host_addr == OFS_DATA & ~divisor_access_bit;
    wire wr_data  = host_wr & host_addr == OFS_DATA & ~divisor_access_bit;
    wire rd_iir   = host_rd & host_addr == OFS_IIR;
    wire wr_fcr   = host_wr & host_addr == OFS_IIR;
    wire rd_lsr   = host_rd & host_addr == OFS_LSR;
    wire rd_msr   = host_rd & host_addr == OFS_MSR;
    wire rd_mcx   = host_rd & host_addr == OFS_MCR & divisor_access_bit;
    wire fen_chg  = wr_fcr & host_wdata[FCR_EN] != fen_reg;
    wire prog     = wr_fcr & host_wdata[FCR_EN];
    wire rx_flush = fen_chg | (prog & host_wdata[FCR_RXRST]);
    wire tx_flush = fen_chg | (prog & host_wdata[FCR_TXRST]);
    wire [AW:0] cap  = fmode ? CAP_FULL : (AW+1)'(1);               // single byte buffer
    wire [AW:0] trig = trig_lvl(trg_reg);

    // receive push: controller or host loopback
    wire       rx_req  = loop ? wr_data : ctl_rx_wr;
    wire [7:0] rx_byte = loop ? host_wdata : ctl_rx_data;
    wire       rx_full = rx_cnt_reg >= cap;
    wire       rx_push = rx_req & ~rx_full & ~rx_flush;
    wire       rx_pop  = rd_data & rx_cnt_reg != '0 & ~rx_flush;
    wire [10:0] rx_head = rx_mem[rx_rp_reg];
    wire [2:0] push_err = loop ? 3'h0 : shadow_err_reg;
    wire       tx_push = wr_data & ~loop & tx_cnt_reg < cap & ~tx_flush;
    wire       tx_pop  = ctl_tx_rd & tx_cnt_reg != '0 & ~tx_flush;

    // modem status view, null-modem twist in loopback
    wire [3:0] msr_now = loop ? {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]}
                              : {dcd_in, ri_in, dsr_in, cts_in};

    // interrupt sources, each gated by its enable
    wire src_line = ier_reg[2] & (overrun_reg | lsr_err_reg != 3'h0);
    wire src_rxt  = ier_reg[0] & host_dr_reg & (~fmode | rx_cnt_reg >= trig);
    wire src_tmo  = ier_reg[0] & tmo_reg;
    wire src_thr  = ier_reg[1] & transmit_holding_empty_flag_int_reg;
    wire src_mdm  = ier_reg[3] & msr_delta_reg != 4'h0;
    wire pending  = src_line | src_rxt | src_tmo | src_thr | src_mdm;
    logic [2:0] iid;

    // priority encoder
    always_comb begin
        if (src_line) begin
            iid = ID_LINE;
        end else if (src_rxt) begin
            iid = ID_RXTRG;
        end else if (src_tmo) begin
            iid = ID_RXTMO;
        end else if (src_thr) begin
            iid = ID_TRANSMIT_HOLDING_EMPTY_FLAG;
        end else begin
            iid = ID_MDM;
        end
    end

    // iir snapshot: captured in the read cycle, so late events wait
    wire [7:0] iir_val = {fmode, fmode, 2'b00, iid, ~pending};
    wire       thr_ack = rd_iir & pending & iid == ID_TRANSMIT_HOLDING_EMPTY_FLAG;
    // enabling the source while the holding side is empty raises it at once
    wire       thr_arm = host_wr & host_addr == OFS_IER & ~divisor_access_bit
                       & host_wdata[1] & ~ier_reg[1] & tx_cnt_reg == '0;

    // host write registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ier_reg <= RST_ZERO;
            lcr_reg <= RST_ZERO;
            mcr_reg <= RST_ZERO;
            scr_reg <= RST_SCR;
            dll_reg <= RST_ZERO;
            dlm_reg <= RST_ZERO;
            dlx_reg <= RST_ZERO;
            fen_reg <= 1'b0;
            mode_reg <= 1'b0;
            trg_reg <= 2'b00;
        end else if (host_wr) begin
            unique case (host_addr)
                OFS_DATA: if (divisor_access_bit) dll_reg <= host_wdata;
                OFS_IER:  begin
                    if (divisor_access_bit) dlm_reg <= host_wdata;
                    else ier_reg <= {4'h0, host_wdata[3:0]};
                end
                OFS_IIR:  begin
                    fen_reg <= host_wdata[FCR_EN];
                    if (host_wdata[FCR_EN]) begin
                        trg_reg  <= host_wdata[7:6];
                        mode_reg <= host_wdata[FCR_MODE];
                    end
                end
                OFS_LCR:  lcr_reg <= {host_wdata[7:3], 1'b0, host_wdata[1:0]};
                OFS_MCR:  if (!divisor_access_bit) mcr_reg <= {3'h0, host_wdata[4:0]};
                OFS_SCR:  begin
                    if (divisor_access_bit) dlx_reg <= host_wdata;
                    else scr_reg <= host_wdata;
                end
                default:  ;                                                     // lsr, msr writes ignored
            endcase
        end
    end

    // extended status/control: timer enable plus reset shadows
    always_ff @(posedge clk) begin
        if (rst) begin
            mcx_reg <= RST_ZERO;
        end else begin
            if (host_wr && host_addr == OFS_MCR && divisor_access_bit) begin
                mcx_reg[MCX_TMREN] <= host_wdata[MCX_TMREN];
            end
            // shadow set wins over the clearing read
            if (prog && host_wdata[FCR_RXRST]) begin
                mcx_reg[MCX_RXSH] <= 1'b1;
            end else if (rd_mcx) begin
                mcx_reg[MCX_RXSH] <= 1'b0;
            end
            if (prog && host_wdata[FCR_TXRST]) begin
                mcx_reg[MCX_TXSH] <= 1'b1;
            end else if (rd_mcx) begin
                mcx_reg[MCX_TXSH] <= 1'b0;
            end
        end
    end

    // receive fifo pointers and counts
    always_ff @(posedge clk) begin
        if (rst || rx_flush) begin
            rx_wp_reg   <= '0;
            rx_rp_reg   <= '0;
            rx_cnt_reg  <= '0;
            err_cnt_reg <= '0;
        end else begin
            if (rx_push) rx_wp_reg <= rx_wp_reg + AW'(1);
            if (rx_pop) rx_rp_reg <= rx_rp_reg + AW'(1);
            rx_cnt_reg <= rx_cnt_reg + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
            // count of erroneous bytes still held
            err_cnt_reg <= err_cnt_reg + (AW+1)'(rx_push & push_err != 3'h0)
                         - (AW+1)'(rx_pop & rx_head[10:8] != 3'h0);
        end
    end

    // receive storage, error flags travel with the byte
    always_ff @(posedge clk) begin
        if (rx_push) rx_mem[rx_wp_reg] <= {push_err, rx_byte};
    end

    // shadow error bits from the controller
    always_ff @(posedge clk) begin
        if (rst || rx_flush) begin
            shadow_err_reg <= 3'h0;
        end else if (ctl_err_wr) begin
            shadow_err_reg <= ctl_err_bits;
        end else if (ctl_rx_wr) begin
            shadow_err_reg <= 3'h0;
        end
    end

    // head byte flags load once, so an lsr read really clears them
    always_ff @(posedge clk) begin
        if (rst || rx_flush || rx_pop) begin
            head_seen_reg <= 1'b0;                                             // next head reloads
        end else if (rx_cnt_reg != '0) begin
            head_seen_reg <= 1'b1;
        end
    end

    // host-visible error bits: head byte errors, set wins over lsr read
    always_ff @(posedge clk) begin
        if (rst || fen_chg) begin
            lsr_err_reg <= 3'h0;
            overrun_reg <= 1'b0;
        end else begin
            lsr_err_reg <= (rd_lsr ? 3'h0 : lsr_err_reg)
                         | (rx_cnt_reg != '0 && !head_seen_reg ? rx_head[10:8] : 3'h0);
            overrun_reg <= (rx_req & rx_full) | (overrun_reg & ~rd_lsr);
        end
    end

    // data ready, delayed by receive timer when enabled
    always_ff @(posedge clk) begin
        if (rst || rx_flush) begin
            host_dr_reg <= 1'b0;
            dly_reg     <= '0;
        end else if (rx_cnt_reg == '0 || (rx_pop && rx_cnt_reg == (AW+1)'(1) && !rx_push)) begin
            host_dr_reg <= 1'b0;
            dly_reg     <= ($bits(dly_reg))'(RX_DELAY_CYC);
        end else if (!mcx_reg[MCX_TMREN] || dly_reg == '0) begin
            host_dr_reg <= 1'b1;
        end else begin
            dly_reg <= dly_reg - ($bits(dly_reg))'(1);
        end
    end

    // receiver timeout flag
    always_ff @(posedge clk) begin
        if (rst || rx_flush) begin
            tmo_reg <= 1'b0;
        end else if (ctl_rx_timeout && rx_cnt_reg != '0) begin
            tmo_reg <= 1'b1;
        end else if (rx_pop) begin
            tmo_reg <= 1'b0;
        end
    end

    // transmit fifo
    always_ff @(posedge clk) begin
        if (rst || tx_flush) begin
            tx_wp_reg  <= '0;
            tx_rp_reg  <= '0;
            tx_cnt_reg <= '0;
        end else begin
            if (tx_push) tx_wp_reg <= tx_wp_reg + AW'(1);
            if (tx_pop) tx_rp_reg <= tx_rp_reg + AW'(1);
            tx_cnt_reg <= tx_cnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        end
    end

    always_ff @(posedge clk) begin
        if (tx_push) tx_mem[tx_wp_reg] <= host_wdata;
    end

    // byte handed to the controller, held until next pop
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_tx_data <= 8'h00;
        end else if (tx_pop) begin
            ctl_tx_data <= tx_mem[tx_rp_reg];
        end
    end

    // holding-empty flag; fifo mode only clears once trigger met
    wire tx_drained = tx_pop && tx_cnt_reg == (AW+1)'(1) && !tx_push;
    wire transmit_holding_empty_flag_set   = tx_drained | tx_flush;
    always_ff @(posedge clk) begin
        if (rst) begin
            transmit_holding_empty_flag_reg <= 1'b1;
        end else if (transmit_holding_empty_flag_set) begin
            transmit_holding_empty_flag_reg <= 1'b1;
        end else if (!fmode && tx_push) begin
            transmit_holding_empty_flag_reg <= 1'b0;
        end else if (fmode && tx_cnt_reg + (AW+1)'(tx_push) >= trig) begin
            transmit_holding_empty_flag_reg <= 1'b0;
        end
    end

    // thr-empty interrupt event, set wins over its clears
    always_ff @(posedge clk) begin
        if (rst || fen_chg) begin
            transmit_holding_empty_flag_int_reg <= 1'b0;
        end else if (tx_drained || thr_arm) begin
            transmit_holding_empty_flag_int_reg <= 1'b1;
        end else if (wr_data || thr_ack) begin
            transmit_holding_empty_flag_int_reg <= 1'b0;
        end
    end

    // modem status deltas; ring uses trailing edge
    always_ff @(posedge clk) begin
        if (rst) begin
            msr_prev_reg  <= 4'h0;
            msr_delta_reg <= 4'h0;
        end else begin
            msr_prev_reg <= msr_now;
            if (fen_chg) begin
                msr_delta_reg <= 4'h0;
            end else begin
                msr_delta_reg <= (rd_msr ? 4'h0 : msr_delta_reg)
                               | {msr_now[3] ^ msr_prev_reg[3], msr_prev_reg[2] & ~msr_now[2],
                                  msr_now[1] ^ msr_prev_reg[1], msr_now[0] ^ msr_prev_reg[0]};
            end
        end
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            host_rdata <= 8'h00;
        end else if (host_rd) begin
            unique case (host_addr)
                OFS_DATA: host_rdata <= divisor_access_bit ? dll_reg : rx_head[7:0];
                OFS_IER:  host_rdata <= divisor_access_bit ? dlm_reg : ier_reg;
                OFS_IIR:  host_rdata <= iir_val;
                OFS_LCR:  host_rdata <= lcr_reg;
                OFS_MCR:  host_rdata <= divisor_access_bit ? mcx_reg : mcr_reg;
                OFS_LSR:  host_rdata <= {err_cnt_reg != '0, transmit_holding_empty_flag_reg, transmit_holding_empty_flag_reg,
                                         lsr_err_reg, overrun_reg, host_dr_reg};
                OFS_MSR:  host_rdata <= {msr_now, msr_delta_reg};
                default:  host_rdata <= divisor_access_bit ? dlx_reg : scr_reg;
            endcase
        end
    end

    // interrupt line and status outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            host_irq       <= 1'b0;
            ctl_data_ready <= 1'b0;
            ctl_tx_avail   <= 1'b0;
        end else begin
            host_irq       <= pending;
            ctl_data_ready <= rx_cnt_reg + (AW+1)'(rx_push) - (AW+1)'(rx_pop) != '0;
            ctl_tx_avail   <= tx_cnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop) != '0;
        end
    end

    // control outputs straight from registers
    assign irq_tristate_n = mcr_reg[MCR_INTEN];
    assign modem_ctl_out  = loop ? 4'h0 : mcr_reg[3:0];
    assign break_out      = lcr_reg[LCR_BRK];
    assign parity_ctl     = (lcr_reg[1:0] == 2'b10) ? lcr_reg[5:3] : 3'h0;
endmodule : hue_top
`default_nettype wire

// [testbench/hue_host_model.sv]
`default_nettype none
// host processor side: one-cycle strobes, never both at once
module hue_host_model (
    input  wire logic       clk,
    output logic      [2:0] host_addr,
    output logic      [7:0] host_wdata,
    output logic            host_wr,
    output logic            host_rd,
    input  wire logic [7:0] host_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial begin
        host_addr  = 3'h0;
        host_wdata = 8'h00;
        host_wr    = 1'b0;
        host_rd    = 1'b0;
    end
    // write strobe; the data bus is scrambled after release so stale bytes never pass
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host_addr  <= a;
        host_wdata <= d;
        host_wr    <= 1'b1;
        @(posedge clk);
        host_wr    <= 1'b0;
        host_wdata <= ~d;
        @(posedge clk);
    endtask : wr
    // read strobe; the answer stands from the following cycle until the next read
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        host_addr <= a;
        host_rd   <= 1'b1;
        @(posedge clk);
        host_rd   <= 1'b0;
        @(posedge clk);
        d = host_rdata;
    endtask : rd
endmodule : hue_host_model
`default_nettype wire

// [testbench/hue_assertions.sv]
`default_nettype none
module hue_assertions
    import hue_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic       host_wr,
    input wire logic       host_rd,
    input wire logic [7:0] host_rdata,
    input wire logic       host_irq,
    input wire logic       irq_tristate_n,
    input wire logic       ctl_rx_wr,
    input wire logic       ctl_data_ready,
    input wire logic [3:0] modem_ctl_out,
    input wire logic       break_out,
    input wire logic [2:0] parity_ctl
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic divisor_access_bit_reg;  // mirror of the divisor access bit
    // offsets 0,1,4,7 change meaning under the divisor access bit
    always_ff @(posedge clk) begin
        if (rst)
            divisor_access_bit_reg <= 1'b0;
        else if (host_wr && host_addr == OFS_LCR)
            divisor_access_bit_reg <= host_wdata[LCR_DIVISOR_ACCESS_BIT];
    end
    wire logic wr_mcr = host_wr && host_addr == OFS_MCR && !divisor_access_bit_reg;  // modem_control write
    wire logic wr_lcr = host_wr && host_addr == OFS_LCR;                 // line_control write
    wire logic rd_iir = host_rd && host_addr == OFS_IIR;                 // identification read
    logic loop_reg;  // mirror of the loopback bit, which hides controller pushes
    always_ff @(posedge clk) begin
        if (rst)
            loop_reg <= 1'b0;
        else if (wr_mcr)
            loop_reg <= host_wdata[MCR_LOOP];
    end
    iir_resv_a: assert property (rd_iir |=> host_rdata[5:4] == 2'h0)
        else $error("identification reserved bits set");
    iir_top_a: assert property (rd_iir |=> host_rdata[7] == host_rdata[6])
        else $error("identification top bits differ");
    idle_id_a: assert property (rd_iir && !host_irq ##1 !host_irq |-> host_rdata[0])
        else $error("pending shown with no interrupt");
    rx_ready_a: assert property (ctl_rx_wr && !host_wr && !host_rd && !loop_reg |=> ctl_data_ready)
        else $error("controller ready flag missing");
    tri_ctl_a: assert property (wr_mcr |=> irq_tristate_n == $past(host_wdata[MCR_INTEN]))
        else $error("tristate control wrong");
    loop_out_a: assert property (wr_mcr |=> modem_ctl_out == ($past(host_wdata[MCR_LOOP]) ? 4'h0 : $past(host_wdata[3:0])))
        else $error("modem control outputs wrong");
    brk_out_a: assert property (wr_lcr |=> break_out == $past(host_wdata[LCR_BRK]))
        else $error("break output wrong");
    par_sel_a: assert property (wr_lcr |=> parity_ctl == ($past(host_wdata[1:0]) == 2'h2 ? $past(host_wdata[5:3]) : 3'h0))
        else $error("parity control wrong");
    mcr_resv_a: assert property (host_rd && host_addr == OFS_MCR && !divisor_access_bit_reg |=> host_rdata[7:5] == 3'h0)
        else $error("modem control reserved bits set");
    temt_mirror_a: assert property (host_rd && host_addr == OFS_LSR |=> host_rdata[6] == host_rdata[5])
        else $error("transmitter empty mirror wrong");
    ier_mask_a: assert property (host_wr && host_addr == OFS_IER && !divisor_access_bit_reg && host_wdata[3:0] == 4'h0 |-> ##2 !host_irq)
        else $error("interrupt with all sources masked");
    cover property (ctl_rx_wr);
    cover property (rd_iir ##1 !host_rdata[0]);
    cover property (wr_mcr && host_wdata[MCR_LOOP]);
endmodule : hue_assertions
bind hue_top hue_assertions u_chk (.clk, .rst, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
    .host_irq, .irq_tristate_n, .ctl_rx_wr, .ctl_data_ready, .modem_ctl_out, .break_out, .parity_ctl);
`default_nettype wire

// [testbench/tb_top.sv]
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hue_pkg::*;
    logic       clk, rst, host_wr, host_rd, host_irq, irq_tristate_n, ctl_tx_avail, ctl_data_ready, break_out;
    logic [2:0] host_addr, eb, parity_ctl;
    logic [3:0] cs, mdm, modem_ctl_out;  // cs: push, error load, timeout, pop
    logic [7:0] host_wdata, host_rdata, ctl_tx_data, rxd, rdat, txd;
    int         n_errors, comparisons, cyc;
    int         lvl[4] = '{1, 4, 8, 14};
    hue_top u_dut (.clk, .rst, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata, .host_irq, .irq_tristate_n,
        .ctl_rx_wr(cs[0]), .ctl_rx_data(rxd), .ctl_err_wr(cs[1]), .ctl_err_bits(eb), .ctl_rx_timeout(cs[2]),
        .ctl_tx_rd(cs[3]), .ctl_tx_data, .ctl_tx_avail, .ctl_data_ready, .cts_in(mdm[0]), .dsr_in(mdm[1]),
        .ri_in(mdm[2]), .dcd_in(mdm[3]), .modem_ctl_out, .break_out, .parity_ctl);
    hue_host_model u_host (.clk, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata);
    // 40 ns clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // one controller strobe; its data bus is scrambled once released
    task automatic ctl(input logic [3:0] s, input logic [7:0] d, input logic [2:0] e);
        cs  <= s;
        rxd <= d;
        eb  <= e;
        @(posedge clk);
        cs  <= 4'h0;
        rxd <= ~d;
        @(posedge clk);
        txd = ctl_tx_data;
        @(posedge clk);
    endtask : ctl
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        u_host.rd(a, rdat);
        `CHK(rdat, e)
    endtask : rdc
    initial begin
        rst = 1'b1;
        {cs, rxd, eb, mdm} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(OFS_LSR, 8'h60);
        rdc(OFS_IIR, 8'h01);
        u_host.wr(OFS_LSR, 8'hFF);
        rdc(OFS_LSR, 8'h60);
        // divisor window
        u_host.wr(OFS_LCR, 8'h80);
        u_host.wr(OFS_DATA, 8'h5A);
        u_host.wr(OFS_IER, 8'hA5);
        u_host.wr(OFS_SCR, 8'h96);
        rdc(OFS_DATA, 8'h5A);
        rdc(OFS_IER, 8'hA5);
        rdc(OFS_SCR, 8'h96);
        u_host.wr(OFS_LCR, 8'h6A);
        rdc(OFS_IER, 8'h00);
        rdc(OFS_LSR, 8'h60);
        `CHK({break_out, parity_ctl}, 4'hD)
        rdc(OFS_LCR, 8'h6A);
        // trigger levels, each with both pointer resets
        u_host.wr(OFS_IER, 8'h01);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(OFS_IIR, {i[1:0], 6'h0F});
            for (int k = 1; k < lvl[i]; k++)
                ctl(4'h1, 8'(k), 3'h0);
            rdc(OFS_IIR, 8'hC1);
            ctl(4'h1, 8'hEE, 3'h0);
            rdc(OFS_IIR, 8'hC4);
            `CHK(host_irq, 1'b1)
            rdc(OFS_DATA, lvl[i] == 1 ? 8'hEE : 8'h01);
            rdc(OFS_IIR, 8'hC1);
        end
        u_host.wr(OFS_LCR, 8'h80);
        rdc(OFS_MCR, 8'h06);
        rdc(OFS_MCR, 8'h00);
        u_host.wr(OFS_LCR, 8'h00);
        // timeout below the trigger
        u_host.wr(OFS_IIR, 8'hCB);
        ctl(4'h1, 8'h42, 3'h0);
        ctl(4'h4, 8'h00, 3'h0);
        rdc(OFS_IIR, 8'hCC);
        rdc(OFS_DATA, 8'h42);
        rdc(OFS_IIR, 8'hC1);
        // framing flag rides the next byte
        u_host.wr(OFS_IER, 8'h04);
        ctl(4'h2, 8'h00, 3'h2);
        ctl(4'h1, 8'h77, 3'h0);
        rdc(OFS_IIR, 8'hC6);
        rdc(OFS_LSR, 8'hE9);
        rdc(OFS_IIR, 8'hC1);
        rdc(OFS_DATA, 8'h77);
        rdc(OFS_LSR, 8'h60);
        // enable change flushes, then single-byte overrun
        ctl(4'h1, 8'h11, 3'h0);
        u_host.wr(OFS_IIR, 8'h00);
        rdc(OFS_LSR, 8'h60);
        u_host.wr(OFS_IIR, 8'h01);
        rdc(OFS_IIR, 8'h01);
        ctl(4'h1, 8'hA1, 3'h0);
        ctl(4'h1, 8'hA2, 3'h0);
        rdc(OFS_LSR, 8'h63);
        rdc(OFS_LSR, 8'h61);
        rdc(OFS_DATA, 8'hA1);
        // transmit holding empty
        u_host.wr(OFS_IER, 8'h02);
        rdc(OFS_IIR, 8'h02);
        rdc(OFS_IIR, 8'h01);
        u_host.wr(OFS_DATA, 8'h3C);
        rdc(OFS_LSR, 8'h00);
        `CHK(ctl_tx_avail, 1'b1)
        ctl(4'h8, 8'h00, 3'h0);
        `CHK(txd, 8'h3C)
        rdc(OFS_IIR, 8'h02);
        u_host.wr(OFS_DATA, 8'h3D);
        rdc(OFS_IIR, 8'h01);
        ctl(4'h8, 8'h00, 3'h0);
        // modem status, then priority over it
        u_host.wr(OFS_IER, 8'h08);
        mdm <= 4'h1;
        repeat (3) @(posedge clk);
        rdc(OFS_IIR, 8'h00);
        rdc(OFS_MSR, 8'h11);
        rdc(OFS_IIR, 8'h01);
        u_host.wr(OFS_IER, 8'h0A);
        mdm <= 4'h0;
        repeat (3) @(posedge clk);
        rdc(OFS_IIR, 8'h02);
        rdc(OFS_IIR, 8'h00);
        u_host.wr(OFS_IER, 8'h00);
        // loopback and interrupt tristate
        u_host.wr(OFS_MCR, 8'h13);
        `CHK(modem_ctl_out, 4'h0)
        u_host.rd(OFS_MSR, rdat);
        `CHK(rdat[7:4], 4'h3)
        u_host.wr(OFS_DATA, 8'h5C);
        repeat (3) @(posedge clk);
        rdc(OFS_DATA, 8'h5C);
        u_host.wr(OFS_MCR, 8'hE8);
        rdc(OFS_MCR, 8'h08);
        `CHK({irq_tristate_n, modem_ctl_out}, 5'h18)
        // receive timer holds data ready back from the host only
        u_host.wr(OFS_LCR, 8'h80);
        u_host.wr(OFS_MCR, 8'h01);
        u_host.wr(OFS_LCR, 8'h00);
        ctl(4'h1, 8'h24, 3'h0);
        `CHK(ctl_data_ready, 1'b1)
        rdc(OFS_LSR, 8'h60);
        repeat (RX_DELAY_CYC) @(posedge clk);
        rdc(OFS_LSR, 8'h61);
        end_of_test();
    end
endmodule : tb_top
`undef CHK
`default_nettype wire
